// ---- src/cpc_pkg.sv ----
// package: offsets, fields, carriers and limits of the codec port control block
package cpc_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL0 = 5'h00;
  localparam logic [4:0] OFF_STAT = 5'h04;
  localparam logic [4:0] OFF_MASK = 5'h08;
  localparam logic [4:0] OFF_CTRL1 = 5'h0c;
  localparam logic [4:0] OFF_FLAGS = 5'h10;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int ASD_LSB = 0;
  localparam int TSD_LSB = 8;
  localparam int DIV_W = 7;
  localparam int EN_BIT = 16;
  localparam int ECS_BIT = 17;
  localparam int ADM_BIT = 18;
  localparam int TTE_BIT = 19;
  localparam int TRE_BIT = 20;
  localparam int ATE_BIT = 21;
  localparam int ECP_LSB = 24;
  localparam int ECP_W = 2;
  localparam int CFS_BIT = 20;
  localparam int ST_W = 3;

  // ------------------------------------------------------------
  // reset values and limits
  // ------------------------------------------------------------
  localparam logic [31:0] CTRL0_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL1_RST = 32'h0000_0000;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;
  localparam int ASD_MIN = 6;
  localparam int TSD_MIN = 16;
  localparam int DIV_MAX = 127;
  localparam int BITS_PER_FRAME = 32;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [ECP_W-1:0] external_prescaler;
    logic audio_tx_irq_enable;
    logic telecom_rx_irq_enable;
    logic telecom_tx_irq_enable;
    logic receive_sampling_mode;
    logic external_clock_select;
    logic en;
    logic [DIV_W-1:0] telecom_rate_divisor;
    logic [DIV_W-1:0] audio_rate_divisor;
  } cpc_ctrl_t;

  // bit 0 telecom tx, bit 1 telecom rx, bit 2 audio tx
  typedef struct packed {
    logic audio_tx_service_flag;
    logic telecom_rx_service_flag;
    logic telecom_tx_service_flag;
  } cpc_flags_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } cpc_av_req_t;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } cpc_av_rsp_t;

endpackage

// ---- src/cpc_rate_div.sv ----
// tick divider: one expire pulse per div input ticks
`timescale 1ns/1ps
module cpc_rate_div #(
  parameter int W = 7
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic tick,
  input wire logic [W-1:0] div,
  output logic expire
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] last;

  if (W < 1 || W > 16) begin : g_bad_w
    $error("cpc_rate_div: W out of range");
  end

  // a zero divisor behaves as one so the chain never stalls
  assign last = (div == '0) ? '0 : div - W'(1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      expire <= 1'b0;
    end else if (!run) begin
      cnt_q <= '0;
      expire <= 1'b0;
    end else begin
      expire <= tick && (cnt_q >= last);
      if (tick) begin
        cnt_q <= (cnt_q >= last) ? '0 : cnt_q + W'(1);
      end
    end
  end

  AST_DIV_WRAP: assert property (@(posedge clk) disable iff (!arst_n)
    run && tick && div > W'(1) && cnt_q == last |=> expire && cnt_q == '0)
    else $error("divider did not expire on its last count");

  AST_DIV_QUIET: assert property (@(posedge clk) disable iff (!arst_n)
    run && cnt_q < last && div > W'(1) |=> !expire)
    else $error("divider expired early");
endmodule

// ---- src/cpc_port_ctrl.sv ----
// codec serial port control fields with Avalon-MM register slave
`timescale 1ns/1ps
// ------------------------------------------------------------
// Overview of operation
// - audio divisor, bits 6:0, values 6-127
// - audio rate is bit clock over 32xdivisor
// - telecom divisor, bits 14:8, values 16-127
// - telecom rate is bit clock over 32xdivisor
// - enable low releases pins to pin controller
// - enabled port overrides sync port unless reassigned
// - external select low: on-chip clock, frequency bit
// - external select high: clock from external pin
// - frame rate is input over prescaler x32
// - sample rate adds divisor to frame division
// - mode low: store on every valid
// - mode high: first valid, then counter expiry
// - telecom tx enable forwards its service flag
// - telecom rx enable forwards its service flag
// - audio tx enable forwards its service flag
// - prescaler divides by code plus one
// - enables gate interrupts only, not flags/dma
// - reset forces port enable to zero
// ------------------------------------------------------------
module cpc_port_ctrl (
  input wire logic clk,
  input wire logic arst_n,
  input wire cpc_pkg::cpc_av_req_t av_req,
  output cpc_pkg::cpc_av_rsp_t av_rsp,
  input wire logic onchip_tick_fast,
  input wire logic onchip_tick_slow,
  input wire logic ext_clk_in,
  input wire cpc_pkg::cpc_flags_t svc_flags,
  input wire logic audio_rx_valid,
  input wire logic telecom_rx_valid,
  input wire logic sync_port_enable,
  input wire logic pin_reassign_bit,
  output logic port_owns_pins,
  output logic sync_port_run,
  output logic frame_tick,
  output logic audio_sample_tick,
  output logic telecom_sample_tick,
  output logic audio_rx_store,
  output logic telecom_rx_store,
  output cpc_pkg::cpc_flags_t fifo_irq_req,
  output cpc_pkg::cpc_flags_t dma_req,
  output logic irq
);
  import cpc_pkg::*;

  // ------------------------------------------------------------
  // register helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] ctrl_word(input cpc_ctrl_t c);
    logic [31:0] w;
    w = '0;
    w[ASD_LSB +: DIV_W] = c.audio_rate_divisor;
    w[TSD_LSB +: DIV_W] = c.telecom_rate_divisor;
    w[EN_BIT] = c.en;
    w[ECS_BIT] = c.external_clock_select;
    w[ADM_BIT] = c.receive_sampling_mode;
    w[TTE_BIT] = c.telecom_tx_irq_enable;
    w[TRE_BIT] = c.telecom_rx_irq_enable;
    w[ATE_BIT] = c.audio_tx_irq_enable;
    w[ECP_LSB +: ECP_W] = c.external_prescaler;
    return w;
  endfunction

  function automatic cpc_ctrl_t ctrl_fields(input logic [31:0] w);
    cpc_ctrl_t c;
    c.audio_rate_divisor = w[ASD_LSB +: DIV_W];
    c.telecom_rate_divisor = w[TSD_LSB +: DIV_W];
    c.en = w[EN_BIT];
    c.external_clock_select = w[ECS_BIT];
    c.receive_sampling_mode = w[ADM_BIT];
    c.telecom_tx_irq_enable = w[TTE_BIT];
    c.telecom_rx_irq_enable = w[TRE_BIT];
    c.audio_tx_irq_enable = w[ATE_BIT];
    c.external_prescaler = w[ECP_LSB +: ECP_W];
    return c;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  cpc_ctrl_t ctrl_q;
  logic cfs_q;
  logic [ST_W-1:0] stat_q;
  logic [ST_W-1:0] mask_q;
  logic [ST_W-1:0] rd_snap_q;
  logic ext_q;
  logic seen_a_q;
  logic seen_t_q;
  logic wait_q;
  logic [31:0] rdata_q;

  logic acc;
  logic wr_go;
  logic rd_go;
  logic ext_edge;
  logic bit_tick;
  logic presc_tick;
  logic [2:0] presc_div;
  logic [5:0] frame_div;
  logic [ST_W-1:0] ev;
  logic [ST_W-1:0] clr;

  // ------------------------------------------------------------
  // Avalon-MM slave: request in cycle 0, waitrequest low in cycle 1
  // ------------------------------------------------------------
  assign av_rsp = '{waitrequest: wait_q, readdata: rdata_q};
  assign acc = (av_req.read || av_req.write) && av_rsp.waitrequest;
  assign wr_go = av_req.write && !av_rsp.waitrequest;
  assign rd_go = av_req.read && !av_rsp.waitrequest;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 1'b1;
    end else if (!wait_q) begin
      wait_q <= 1'b1;
    end else if (av_req.read || av_req.write) begin
      wait_q <= 1'b0;
    end
  end

  // read data is captured one edge ahead of the taking edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
      rd_snap_q <= '0;
    end else if (acc && av_req.read) begin
      rdata_q <= '0;
      rd_snap_q <= '0;
      unique case (av_req.address)
        OFF_CTRL0: rdata_q <= ctrl_word(ctrl_q);
        OFF_CTRL1: rdata_q[CFS_BIT] <= cfs_q;
        OFF_STAT: begin
          rdata_q[ST_W-1:0] <= stat_q;
          rd_snap_q <= stat_q;
        end
        OFF_MASK: rdata_q[ST_W-1:0] <= mask_q;
        OFF_FLAGS: rdata_q[ST_W-1:0] <= svc_flags;
        default: rdata_q <= '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  // every field gets a defined value, only enable must be zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= ctrl_fields(CTRL0_RST);
    end else if (wr_go && av_req.address == OFF_CTRL0) begin
      ctrl_q <= ctrl_fields(merge(ctrl_word(ctrl_q), av_req.writedata,
                                  av_req.byteenable));
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfs_q <= CTRL1_RST[CFS_BIT];
    end else if (wr_go && av_req.address == OFF_CTRL1 && av_req.byteenable[2]) begin
      cfs_q <= av_req.writedata[CFS_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= MASK_RST;
    end else if (wr_go && av_req.address == OFF_MASK && av_req.byteenable[0]) begin
      mask_q <= av_req.writedata[ST_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // pin ownership
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_owns_pins <= 1'b0;
      sync_port_run <= 1'b0;
    end else begin
      port_owns_pins <= ctrl_q.en;
      sync_port_run <= sync_port_enable && (!ctrl_q.en || pin_reassign_bit);
    end
  end

  // ------------------------------------------------------------
  // clock selection and rate chain
  // ------------------------------------------------------------
  // the external pin is synchronous here, so a plain edge detect serves
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_clk_in;
    end
  end

  assign ext_edge = ext_clk_in && !ext_q;
  assign presc_div = {1'b0, ctrl_q.external_prescaler} + 3'h1;
  assign frame_div = 6'(BITS_PER_FRAME);

  cpc_rate_div #(.W(3)) u_presc (
    .clk(clk),
    .arst_n(arst_n),
    .run(ctrl_q.en && ctrl_q.external_clock_select),
    .tick(ext_edge),
    .div(presc_div),
    .expire(presc_tick)
  );

  // prescaler bypassed while the on-chip clock is in use
  assign bit_tick = ctrl_q.external_clock_select ? presc_tick
                  : (cfs_q ? onchip_tick_slow : onchip_tick_fast);

  cpc_rate_div #(.W(6)) u_frame (
    .clk(clk),
    .arst_n(arst_n),
    .run(ctrl_q.en),
    .tick(bit_tick),
    .div(frame_div),
    .expire(frame_tick)
  );

  // sample rates count frames, so rate = bit clock / (32 x divisor)
  cpc_rate_div #(.W(DIV_W)) u_audio (
    .clk(clk),
    .arst_n(arst_n),
    .run(ctrl_q.en),
    .tick(frame_tick),
    .div(ctrl_q.audio_rate_divisor),
    .expire(audio_sample_tick)
  );

  cpc_rate_div #(.W(DIV_W)) u_telecom (
    .clk(clk),
    .arst_n(arst_n),
    .run(ctrl_q.en),
    .tick(frame_tick),
    .div(ctrl_q.telecom_rate_divisor),
    .expire(telecom_sample_tick)
  );

  // ------------------------------------------------------------
  // receive sampling mode
  // ------------------------------------------------------------
  // with a latching codec the valid bit never drops, so the counter paces stores
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_a_q <= 1'b0;
      seen_t_q <= 1'b0;
      audio_rx_store <= 1'b0;
      telecom_rx_store <= 1'b0;
    end else if (!ctrl_q.en) begin
      seen_a_q <= 1'b0;
      seen_t_q <= 1'b0;
      audio_rx_store <= 1'b0;
      telecom_rx_store <= 1'b0;
    end else if (!ctrl_q.receive_sampling_mode) begin
      seen_a_q <= 1'b0;
      seen_t_q <= 1'b0;
      audio_rx_store <= audio_rx_valid;
      telecom_rx_store <= telecom_rx_valid;
    end else begin
      seen_a_q <= seen_a_q || audio_rx_valid;
      seen_t_q <= seen_t_q || telecom_rx_valid;
      audio_rx_store <= seen_a_q ? audio_sample_tick : audio_rx_valid;
      telecom_rx_store <= seen_t_q ? telecom_sample_tick : telecom_rx_valid;
    end
  end

  // ------------------------------------------------------------
  // service flags, dma and interrupts
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_req <= '0;
      fifo_irq_req <= '0;
    end else begin
      dma_req <= svc_flags;
      fifo_irq_req.telecom_tx_service_flag <= svc_flags.telecom_tx_service_flag && ctrl_q.telecom_tx_irq_enable;
      fifo_irq_req.telecom_rx_service_flag <= svc_flags.telecom_rx_service_flag && ctrl_q.telecom_rx_irq_enable;
      fifo_irq_req.audio_tx_service_flag <= svc_flags.audio_tx_service_flag && ctrl_q.audio_tx_irq_enable;
    end
  end

  // a rising flag sets status; only bits that were read get cleared
  assign ev = svc_flags & ~dma_req;
  assign clr = (rd_go && av_req.address == OFF_STAT) ? rd_snap_q : '0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~clr) | ev;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((stat_q & ~clr) | ev) & mask_q);
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_ASD_WRITE: assert property (wr_go && av_req.address == OFF_CTRL0 &&
    av_req.byteenable[0] |=> ctrl_q.audio_rate_divisor == $past(av_req.writedata[6:0]))
    else $error("audio divisor not stored");

  AST_TSD_WRITE: assert property (wr_go && av_req.address == OFF_CTRL0 &&
    av_req.byteenable[1] |=> ctrl_q.telecom_rate_divisor == $past(av_req.writedata[14:8]))
    else $error("telecom divisor not stored");

  AST_PINS_RELEASE: assert property (!ctrl_q.en |=> !port_owns_pins)
    else $error("pins held while port disabled");

  AST_SYNC_PRIO: assert property (ctrl_q.en && !pin_reassign_bit |=> !sync_port_run)
    else $error("sync port ran against enabled port");

  AST_ONCHIP_SEL: assert property (!ctrl_q.external_clock_select && !cfs_q |-> bit_tick == onchip_tick_fast)
    else $error("on-chip clock not selected");

  AST_EXT_IGNORE: assert property (ctrl_q.external_clock_select && ctrl_q.en && !ext_edge
    |=> !presc_tick)
    else $error("prescaler ticked without an external edge");

  AST_MODE0_STORE: assert property (ctrl_q.en && !ctrl_q.receive_sampling_mode && audio_rx_valid
    |=> audio_rx_store)
    else $error("valid word not stored");

  AST_MODE1_HOLD: assert property (ctrl_q.en && ctrl_q.receive_sampling_mode && seen_t_q &&
    !telecom_sample_tick ##1 ctrl_q.receive_sampling_mode && ctrl_q.en |-> !telecom_rx_store)
    else $error("stored without counter expiry");

  AST_TTE_GATE: assert property (!ctrl_q.telecom_tx_irq_enable |=> !fifo_irq_req.telecom_tx_service_flag)
    else $error("telecom tx request not masked");

  AST_TRE_PASS: assert property (ctrl_q.telecom_rx_irq_enable && svc_flags.telecom_rx_service_flag |=> fifo_irq_req.telecom_rx_service_flag)
    else $error("telecom rx request not forwarded");

  AST_ATE_GATE: assert property (ctrl_q.audio_tx_irq_enable ##0 svc_flags.audio_tx_service_flag |=> fifo_irq_req.audio_tx_service_flag)
    else $error("audio tx request not forwarded");

  AST_DMA_FREE: assert property (svc_flags.audio_tx_service_flag && !ctrl_q.audio_tx_irq_enable |=> dma_req.audio_tx_service_flag)
    else $error("dma request blocked by enable");

  AST_STICKY: assert property (ev[0] |=> stat_q[0] ##1 (stat_q[0] || $past(clr[0])))
    else $error("status bit lost");

  CV_EXT_FRAME: cover property (ctrl_q.external_clock_select && frame_tick);
  CV_MODE1_TICK: cover property (ctrl_q.receive_sampling_mode && seen_a_q && audio_rx_store);
  CV_IRQ: cover property ($rose(irq));
  CV_STAT_READ: cover property (rd_go && av_req.address == OFF_STAT && clr != '0);
endmodule

// ---- tb/cpc_codec_model.sv ----
// far-side codec model: free-running external bit clock and per-frame receive valid pulses
`timescale 1ns/1ps
module cpc_codec_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic frame_in,
  input wire logic valid_on,
  output logic ext_clk,
  output logic audio_valid,
  output logic telecom_valid
);
  logic [1:0] div_q;

  // ------------------------------------------------------------
  // oscillator: four system cycles per period, runs free
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end
  assign ext_clk = div_q[1];

  // ------------------------------------------------------------
  // codec marks a fresh word in every frame while valid_on is set, one cycle after the strobe
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      audio_valid <= 1'b0;
      telecom_valid <= 1'b0;
    end else begin
      audio_valid <= frame_in & valid_on;
      telecom_valid <= frame_in & valid_on;
    end
  end
endmodule

// ---- tb/test_codec_port_control_fields.sv ----
// self-checking bench for the codec port control block
`timescale 1ns/1ps
module test_codec_port_control_fields;
  import cpc_pkg::*;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [2:0] flags;
    logic se;
    logic rb;
    logic own;
    logic run;
    logic [2:0] irqx;
    logic [2:0] dmax;
  } cpc_row_t;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  cpc_av_req_t av_req = '{byteenable: 4'hf, default: '0};
  cpc_av_rsp_t av_rsp;
  logic onchip_tick_fast = 1'b0;
  logic onchip_tick_slow = 1'b0;
  logic [1:0] slow_cnt = 2'h0;
  logic ext_clk_in;
  cpc_flags_t svc_flags = '0;
  logic audio_rx_valid, telecom_rx_valid;
  logic sync_port_enable = 1'b0;
  logic pin_reassign_bit = 1'b0;
  logic port_owns_pins, sync_port_run, frame_tick;
  logic audio_sample_tick, telecom_sample_tick, audio_rx_store, telecom_rx_store, irq;
  cpc_flags_t fifo_irq_req, dma_req;
  logic valid_on = 1'b0;
  logic clr = 1'b0;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0, f_last = 0, f_int = 0, a_last = 0, a_int = 0, t_last = 0, t_int = 0;
  int n_frame = 0, n_av = 0, n_tv = 0, n_as = 0, n_ts = 0, n_ak = 0, n_tk = 0;
  localparam cpc_row_t ROWS [6] = '{
    '{32'h0000_0000, 3'h7, 1'b1, 1'b0, 1'b0, 1'b1, 3'h0, 3'h7},
    '{32'h0009_0000, 3'h7, 1'b1, 1'b0, 1'b1, 1'b0, 3'h1, 3'h7},
    '{32'h0011_0000, 3'h2, 1'b1, 1'b1, 1'b1, 1'b1, 3'h2, 3'h2},
    '{32'h0021_0000, 3'h4, 1'b0, 1'b1, 1'b1, 1'b0, 3'h4, 3'h4},
    '{32'h0039_0000, 3'h3, 1'b0, 1'b0, 1'b1, 1'b0, 3'h3, 3'h3},
    '{32'h0038_0000, 3'h5, 1'b1, 1'b1, 1'b0, 1'b1, 3'h5, 3'h5}};

  initial begin
    forever #20 clk = ~clk;
  end

  cpc_port_ctrl i_cpc_port_ctrl (.clk(clk), .arst_n(arst_n), .av_req(av_req), .av_rsp(av_rsp),
    .onchip_tick_fast(onchip_tick_fast), .onchip_tick_slow(onchip_tick_slow),
    .ext_clk_in(ext_clk_in), .svc_flags(svc_flags), .audio_rx_valid(audio_rx_valid),
    .telecom_rx_valid(telecom_rx_valid), .sync_port_enable(sync_port_enable),
    .pin_reassign_bit(pin_reassign_bit), .port_owns_pins(port_owns_pins),
    .sync_port_run(sync_port_run), .frame_tick(frame_tick),
    .audio_sample_tick(audio_sample_tick), .telecom_sample_tick(telecom_sample_tick),
    .audio_rx_store(audio_rx_store), .telecom_rx_store(telecom_rx_store),
    .fifo_irq_req(fifo_irq_req), .dma_req(dma_req), .irq(irq));

  cpc_codec_model i_cpc_codec_model (.clk(clk), .arst_n(arst_n), .frame_in(frame_tick),
    .valid_on(valid_on), .ext_clk(ext_clk_in), .audio_valid(audio_rx_valid),
    .telecom_valid(telecom_rx_valid));

  // ------------------------------------------------------------
  // on-chip bit clocks: fast every 2 cycles, slow every 3
  // ------------------------------------------------------------
  always @(posedge clk) begin
    onchip_tick_fast <= ~onchip_tick_fast;
    slow_cnt <= (slow_cnt == 2'h2) ? 2'h0 : slow_cnt + 2'h1;
    onchip_tick_slow <= (slow_cnt == 2'h2);
  end

  // ------------------------------------------------------------
  // monitor: pulse intervals and counts
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (frame_tick === 1'b1) begin
      f_int <= cyc - f_last;
      f_last <= cyc;
      n_frame <= n_frame + 1;
    end
    if (audio_sample_tick === 1'b1) begin
      a_int <= cyc - a_last;
      a_last <= cyc;
    end
    if (telecom_sample_tick === 1'b1) begin
      t_int <= cyc - t_last;
      t_last <= cyc;
    end
    if (clr) begin
      n_av <= 0;
      n_tv <= 0;
      n_as <= 0;
      n_ts <= 0;
      n_ak <= 0;
      n_tk <= 0;
    end else begin
      n_av <= n_av + int'(audio_rx_valid === 1'b1);
      n_tv <= n_tv + int'(telecom_rx_valid === 1'b1);
      n_as <= n_as + int'(audio_rx_store === 1'b1);
      n_ts <= n_ts + int'(telecom_rx_store === 1'b1);
      // ticks only count once the first valid word has been seen
      n_ak <= n_ak + int'(audio_sample_tick === 1'b1 && n_av > 0);
      n_tk <= n_tk + int'(telecom_sample_tick === 1'b1 && n_tv > 0);
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic print_verdict();
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge, released only after it
  task automatic bus(input logic wr_en, input logic [4:0] adr, input logic [31:0] wd,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    av_req.read <= ~wr_en;
    av_req.write <= wr_en;
    av_req.address <= adr;
    av_req.writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (av_rsp.waitrequest !== 1'b0);
    q = av_rsp.readdata;
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
    // answer comes one cycle after the request is seen
    chk(n, 32'd2);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic wait_frames(input int k);
    int t;
    t = n_frame + k;
    repeat (40000) begin
      @(posedge clk);
      if (n_frame >= t) break;
    end
    @(negedge clk);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(OFF_CTRL0, CTRL0_RST);
    rd_chk(OFF_CTRL1, CTRL1_RST);
    rd_chk(OFF_MASK, 32'h0);
    wr(OFF_CTRL0, 32'hffff_ffff);
    rd_chk(OFF_CTRL0, 32'h033f_7f7f);
    wr(OFF_CTRL1, 32'hffff_ffff);
    rd_chk(OFF_CTRL1, 32'h0010_0000);
    wr(5'h14, 32'h0);
    rd_chk(5'h14, 32'h0);
    rd_chk(OFF_CTRL0, 32'h033f_7f7f);
    for (int i = 0; i < 6; i++) begin
      wr(OFF_CTRL0, ROWS[i].ctrl);
      svc_flags <= ROWS[i].flags;
      sync_port_enable <= ROWS[i].se;
      pin_reassign_bit <= ROWS[i].rb;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(port_owns_pins, ROWS[i].own);
      chk(sync_port_run, ROWS[i].run);
      chk(fifo_irq_req, ROWS[i].irqx);
      chk(dma_req, ROWS[i].dmax);
    end
    // status and interrupt: set, mask, read-clear
    @(posedge clk);
    svc_flags <= 3'h0;
    wr(OFF_MASK, 32'h0);
    rd_chk(OFF_STAT, 32'h7);
    rd_chk(OFF_STAT, 32'h0);
    svc_flags <= 3'h4;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(irq, 1'b0);
    rd_chk(OFF_FLAGS, 32'h4);
    rd_chk(OFF_STAT, 32'h4);
    rd_chk(OFF_STAT, 32'h0);
    wr(OFF_MASK, 32'h7);
    rd_chk(OFF_MASK, 32'h7);
    svc_flags <= 3'h5;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(irq, 1'b1);
    rd_chk(OFF_STAT, 32'h1);
    @(negedge clk);
    chk(irq, 1'b0);
    // on-chip clock: fast tick every 2 cycles gives 64-cycle frames
    wr(OFF_CTRL1, 32'h0);
    wr(OFF_CTRL0, 32'h0001_7f06);
    wait_frames(2);
    chk(f_int, 64);
    wait_frames(14);
    chk(a_int, 384);
    wait_frames(256);
    chk(t_int, 8128);
    wr(OFF_CTRL1, 32'h0010_0000);
    wait_frames(2);
    chk(f_int, 96);
    // external clock, one rising edge every 4 cycles
    wr(OFF_CTRL0, 32'h0003_1006);
    wait_frames(34);
    chk(f_int, 128);
    chk(a_int, 768);
    chk(t_int, 2048);
    for (int c = 1; c < 4; c++) begin
      wr(OFF_CTRL0, 32'h0003_1006 | (32'(c) << 24));
      wait_frames(2);
      chk(f_int, 128 * (c + 1));
    end
    // receive storing, mode 0 then mode 1
    wr(OFF_CTRL0, 32'h0001_1006);
    clr <= 1'b1;
    valid_on <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wait_frames(8);
    @(posedge clk);
    valid_on <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(n_as, n_av);
    chk(n_ts, n_tv);
    chk(n_av > 5, 1'b1);
    wr(OFF_CTRL0, 32'h0000_1006);
    wr(OFF_CTRL0, 32'h0005_1006);
    clr <= 1'b1;
    valid_on <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wait_frames(20);
    repeat (2000) begin
      @(posedge clk);
      if (audio_sample_tick === 1'b1) break;
    end
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(n_as, n_ak + 1);
    chk(n_ts, n_tk + 1);
    chk(n_ak > 1, 1'b1);
    // reset in mid-run
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(port_owns_pins, 1'b0);
    chk(av_rsp.waitrequest, 1'b1);
    @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(OFF_CTRL0, CTRL0_RST);
    print_verdict();
  end
endmodule
